// ===== hdl/ufipc_ctrl.sv
// control, threshold, parity and interrupt logic of the serial port
`timescale 1ns/1ns
`default_nettype none

module ufipc_ctrl #(
  parameter int DEPTH = 16 // fifo depth in entries
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // fifo levels and events from the datapath, same clock
  input wire logic [$clog2(DEPTH+1)-1:0] tx_level_i,
  input wire logic [$clog2(DEPTH+1)-1:0] rx_level_i,
  input wire ufipc_pkg::ufipc_err_s err_evt_i,
  // character parity paths
  input wire logic [7:0] tx_data_i,
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_data_i,
  input wire logic rx_par_i,
  // modem status pins, asynchronous
  input wire ufipc_pkg::ufipc_modem_s modem_i,
  // configuration and results
  output ufipc_pkg::ufipc_cfg_s cfg_o,
  output logic tx_par_bit_o,
  output logic irq_o
);
  import ufipc_pkg::*;

  localparam int LW = $clog2(DEPTH + 1);

  // ****************************************************************
  // helper functions
  // ****************************************************************

  // threshold code to entry count, in eighths of the depth
  function automatic logic [LW-1:0] thr_count(input logic [2:0] code);
    int n;
    n = 4;
    case (code)
      tx_threshold_one_eighth: n = 1;
      LVL_TWO_EIGHTHS: n = 2;
      LVL_FOUR_EIGHTHS: n = 4;
      LVL_SIX_EIGHTHS: n = 6;
      tx_threshold_seven_eighths: n = 7;
      default: n = 4;
    endcase
    thr_count = LW'((DEPTH * n) / 8);
  endfunction

  // parity bit for a character under a given mode
  function automatic logic par_of(input ufipc_parity_e m, input logic [7:0] d);
    case (m)
      parity_even: par_of = ^d;
      parity_odd: par_of = ~^d;
      parity_forced_one: par_of = 1'b1;
      default: par_of = 1'b0;
    endcase
  endfunction

  // byte-lane merge of a write into an old word
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0] sel);
    logic [31:0] m;
    m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    merge = (old & ~m) | (wd & m);
  endfunction

  // control word as software sees it; the struct order differs from the
  // register layout, so each field is placed at its own position
  function automatic logic [31:0] ctrl_word(input ufipc_cfg_s c);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[CTRL_FIFO_EN] = c.fifo_en;
    w[CTRL_IR_EN] = c.infrared_enable_bit;
    w[CTRL_IR_LP] = c.infrared_low_power_bit;
    w[CTRL_PAR_LSB +: 3] = c.parity;
    ctrl_word = w;
  endfunction

  // threshold word: both codes in their own fields, the rest reads zero
  function automatic logic [31:0] lvl_word(input logic [2:0] tx, input logic [2:0] rx);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[LVL_TX_LSB +: 3] = tx;
    w[LVL_RX_LSB +: 3] = rx;
    lvl_word = w;
  endfunction

  // ****************************************************************
  // state
  // ****************************************************************
  ufipc_cfg_s cfg_r, cfg_nxt; // enables and parity mode
  logic [2:0] tx_lvl_r, tx_lvl_nxt; // transmit threshold code
  logic [2:0] rx_lvl_r, rx_lvl_nxt; // receive threshold code
  logic [10:0] ris_r, ris_nxt; // raw sticky status
  logic [10:0] ien_r, ien_nxt; // enable mask
  logic irq_r, irq_nxt;
  logic ack_r, ack_nxt;
  logic [31:0] rdat_r, rdat_nxt;
  logic tx_par_r, tx_par_nxt;
  logic [LW-1:0] tx_prev_r, tx_prev_nxt; // level one cycle ago
  logic rx_above_r, rx_above_nxt; // receive level was at threshold
  // the modem pins come from another device, so they pass two flops;
  // mprev_r holds the settled level one cycle back for change detection
  ufipc_modem_s msync1_r, msync2_r, mprev_r; // pin synchroniser

  // combinational helpers
  logic req; // new bus request this cycle
  logic wr; // write strobe
  logic [31:0] wword; // merged write value
  logic [LW-1:0] tx_thr, rx_thr;
  logic rx_above;
  logic [10:0] set_v, clr_v;
  ufipc_parity_e new_par;

  // ****************************************************************
  // next-state logic
  // ****************************************************************

  // bus timing: a request is taken at the edge where it is first seen,
  // writes commit at that edge and ack stands for the following cycle;
  // the ack_r gate keeps a request still held in the ack cycle from being
  // taken twice, so a master can start the next transfer right after the ack cycle
  // bus decode, register writes and interrupt status
  always_comb begin
    cfg_nxt = cfg_r;
    tx_lvl_nxt = tx_lvl_r;
    rx_lvl_nxt = rx_lvl_r;
    ien_nxt = ien_r;
    clr_v = '0;
    set_v = '0;
    rdat_nxt = rdat_r;
    // ack only once per request, so the master can release it
    req = wb_cyc_i & wb_stb_i & ~ack_r;
    ack_nxt = req;
    wr = req & wb_we_i;
    wword = 32'h0000_0000;
    new_par = parity_none;

    if (wr) begin
      case (wb_adr_i)
        OFS_CTRL: begin
          wword = merge(ctrl_word(cfg_r), wb_dat_i, wb_sel_i);
          cfg_nxt.fifo_en = wword[CTRL_FIFO_EN];
          cfg_nxt.infrared_enable_bit = wword[CTRL_IR_EN];
          cfg_nxt.infrared_low_power_bit = wword[CTRL_IR_LP];
          new_par = ufipc_parity_e'(wword[CTRL_PAR_LSB +: 3]);
          // unknown codes are dropped so readback stays one of five
          if (wword[CTRL_PAR_LSB +: 3] <= 3'h4) begin
            cfg_nxt.parity = new_par;
          end
        end
        OFS_LVL: begin
          wword = merge(lvl_word(tx_lvl_r, rx_lvl_r), wb_dat_i, wb_sel_i);
          // only the five legal depths are accepted per field
          if (wword[LVL_TX_LSB +: 3] <= tx_threshold_seven_eighths) begin
            tx_lvl_nxt = wword[LVL_TX_LSB +: 3];
          end
          if (wword[LVL_RX_LSB +: 3] <= rx_threshold_seven_eighths) begin
            rx_lvl_nxt = wword[LVL_RX_LSB +: 3];
          end
        end
        OFS_IEN: begin
          wword = merge({21'h0, ien_r}, wb_dat_i, wb_sel_i);
          ien_nxt = wword[10:0];
        end
        OFS_ICLR: begin
          wword = merge(32'h0, wb_dat_i, wb_sel_i);
          clr_v = wword[10:0];
        end
        OFS_IDIS: begin
          wword = merge(32'h0, wb_dat_i, wb_sel_i);
          ien_nxt = ien_r & ~wword[10:0];
        end
        default: begin
          // unmapped or read-only offsets: write ignored, still acked
          wword = 32'h0000_0000;
        end
      endcase
    end

    // thresholds; without fifos the port behaves as one-deep
    if (cfg_r.fifo_en) begin
      tx_thr = thr_count(tx_lvl_r);
      rx_thr = thr_count(rx_lvl_r);
    end else begin
      tx_thr = '0;
      rx_thr = LW'(1);
    end

    // transmit source fires on the downward crossing only
    set_v[IRQ_TX] = (tx_prev_r > tx_thr) && (tx_level_i <= tx_thr);
    // receive source fires on reaching the threshold
    rx_above = (rx_level_i >= rx_thr);
    set_v[IRQ_RX] = rx_above & ~rx_above_r;
    set_v[IRQ_OE] = err_evt_i.overrun;
    set_v[IRQ_BE] = err_evt_i.brk;
    set_v[IRQ_FE] = err_evt_i.framing;
    set_v[IRQ_RT] = err_evt_i.timeout;
    // parity checked with the same mode used for sending
    set_v[IRQ_PE] = rx_valid_i && (cfg_r.parity != parity_none) &&
                    (rx_par_i != par_of(cfg_r.parity, rx_data_i));
    // modem inputs: any change on the synchronised level
    set_v[IRQ_DSR] = msync2_r.dsr ^ mprev_r.dsr;
    set_v[IRQ_DCD] = msync2_r.dcd ^ mprev_r.dcd;
    set_v[IRQ_CTS] = msync2_r.cts ^ mprev_r.cts;
    set_v[IRQ_RI] = msync2_r.ri ^ mprev_r.ri;

    // a new event in the clear cycle wins over the clear
    ris_nxt = (ris_r & ~clr_v) | set_v;
    // receive bit also drops once the level is back below
    ris_nxt[IRQ_RX] = ris_nxt[IRQ_RX] & rx_above;
    rx_above_nxt = rx_above;
    tx_prev_nxt = tx_level_i;

    // the line follows enabled sources only; it is registered from the
    // next status, so it drops at the same edge that commits the clear
    irq_nxt = |(ris_nxt & ien_nxt);

    // forced modes ignore the data bits entirely; the mode in force this
    // cycle is used, so a mode write shows one edge after it commits
    tx_par_nxt = par_of(cfg_r.parity, tx_data_i);

    // read data, latched with the acknowledge
    if (req && !wb_we_i) begin
      case (wb_adr_i)
        OFS_CTRL: rdat_nxt = ctrl_word(cfg_r);
        OFS_LVL: rdat_nxt = lvl_word(tx_lvl_r, rx_lvl_r);
        OFS_RIS: rdat_nxt = {21'h0, ris_r};
        OFS_MIS: rdat_nxt = {21'h0, ris_r & ien_r};
        OFS_IEN: rdat_nxt = {21'h0, ien_r};
        default: rdat_nxt = 32'h0000_0000;
      endcase
    end else if (req) begin
      rdat_nxt = 32'h0000_0000;
    end
  end

  // ****************************************************************
  // registers
  // ****************************************************************

  // all state registered here; reset is synchronous
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      // configuration and thresholds back to defaults
      cfg_r <= '{fifo_en: 1'b0, infrared_enable_bit: 1'b0,
                 infrared_low_power_bit: 1'b0, parity: parity_none};
      tx_lvl_r <= LVL_RST;
      rx_lvl_r <= LVL_RST;
      // status clear and every source masked
      ris_r <= '0;
      ien_r <= IEN_RST;
      // bus and result outputs idle
      irq_r <= 1'b0;
      ack_r <= 1'b0;
      rdat_r <= 32'h0000_0000;
      tx_par_r <= 1'b0;
      tx_prev_r <= '0;
      rx_above_r <= 1'b0;
      // synchroniser starts at the idle pin level, so no false change
      msync1_r <= '0;
      msync2_r <= '0;
      mprev_r <= '0;
    end else begin
      // every register takes its next value
      cfg_r <= cfg_nxt;
      tx_lvl_r <= tx_lvl_nxt;
      rx_lvl_r <= rx_lvl_nxt;
      ris_r <= ris_nxt;
      ien_r <= ien_nxt;
      irq_r <= irq_nxt;
      ack_r <= ack_nxt;
      rdat_r <= rdat_nxt;
      tx_par_r <= tx_par_nxt;
      tx_prev_r <= tx_prev_nxt;
      rx_above_r <= rx_above_nxt;
      // two stages before any logic looks at the pins
      msync1_r <= modem_i;
      msync2_r <= msync1_r;
      mprev_r <= msync2_r;
    end
  end

  // ****************************************************************
  // outputs, all straight from flip-flops
  // ****************************************************************
  assign wb_dat_o = rdat_r;
  assign wb_ack_o = ack_r;
  assign cfg_o = cfg_r;
  assign tx_par_bit_o = tx_par_r;
  assign irq_o = irq_r;

endmodule

`default_nettype wire

// ===== hdl/ufipc_pkg.sv
// constants and carrier types for the serial port control and interrupt block
//
// Behaviour
// - infrared enable bit, plus optional low-power bit
// - one enable switches both FIFOs together
// - transmit threshold: 1,2,4,6,7 eighths
// - independent receive threshold, same five depths
// - both thresholds read back unchanged
// - eleven interrupt sources, each with mask
// - only enabled sources drive the interrupt
// - disable chosen sources, others keep enable
// - raw and masked interrupt status reads
// - clear write clears only named sources
// - one parity setting for transmit and receive
// - forced modes send fixed one or zero
// - parity mode reads back, all five distinct
// - transmit interrupt when level falls past threshold
package ufipc_pkg;

  // ****************************************************************
  // register offsets (byte addresses, one word each)
  // ****************************************************************
  localparam logic [7:0] OFS_CTRL = 8'h00; // enables and parity mode
  localparam logic [7:0] OFS_LVL = 8'h04; // fifo interrupt thresholds
  localparam logic [7:0] OFS_RIS = 8'h08; // raw status, read only
  localparam logic [7:0] OFS_MIS = 8'h0C; // masked status, read only
  localparam logic [7:0] OFS_IEN = 8'h10; // enable mask, read/write
  localparam logic [7:0] OFS_ICLR = 8'h14; // write one to clear status
  localparam logic [7:0] OFS_IDIS = 8'h18; // write one to disable source

  // ****************************************************************
  // field positions and reset values
  // ****************************************************************
  localparam int CTRL_FIFO_EN = 0;
  localparam int CTRL_IR_EN = 1;
  localparam int CTRL_IR_LP = 2;
  localparam int CTRL_PAR_LSB = 3;
  localparam int LVL_TX_LSB = 0;
  localparam int LVL_RX_LSB = 3;
  localparam logic [2:0] LVL_RST = 3'h2; // half full for both
  localparam logic [10:0] IEN_RST = 11'h000;

  // interrupt bit positions
  localparam int IRQ_OE = 0;
  localparam int IRQ_BE = 1;
  localparam int IRQ_PE = 2;
  localparam int IRQ_FE = 3;
  localparam int IRQ_RT = 4;
  localparam int IRQ_TX = 5;
  localparam int IRQ_RX = 6;
  localparam int IRQ_DSR = 7;
  localparam int IRQ_DCD = 8;
  localparam int IRQ_CTS = 9;
  localparam int IRQ_RI = 10;
  localparam int NUM_IRQ = 11;

  // threshold codes, shared layout for both directions
  localparam logic [2:0] tx_threshold_one_eighth = 3'h0;
  localparam logic [2:0] rx_threshold_one_eighth = 3'h0;
  localparam logic [2:0] LVL_TWO_EIGHTHS = 3'h1;
  localparam logic [2:0] LVL_FOUR_EIGHTHS = 3'h2;
  localparam logic [2:0] LVL_SIX_EIGHTHS = 3'h3;
  localparam logic [2:0] tx_threshold_seven_eighths = 3'h4;
  localparam logic [2:0] rx_threshold_seven_eighths = 3'h4;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [2:0] {
    parity_none = 3'b000,
    parity_even = 3'b001,
    parity_odd = 3'b010,
    parity_forced_one = 3'b011,
    parity_forced_zero = 3'b100
  } ufipc_parity_e;

  // configuration handed to the serial datapath
  typedef struct packed {
    logic fifo_en;
    logic infrared_enable_bit;
    logic infrared_low_power_bit;
    ufipc_parity_e parity;
  } ufipc_cfg_s;

  // receive error pulses from the datapath
  typedef struct packed {
    logic overrun;
    logic brk;
    logic framing;
    logic timeout;
  } ufipc_err_s;

  // modem status pins, asynchronous
  typedef struct packed {
    logic dsr;
    logic dcd;
    logic cts;
    logic ri;
  } ufipc_modem_s;

endpackage

// ===== tb/ufipc_checker.sv
// port assertions for the serial port control block
`timescale 1ns/1ns
`default_nettype none
module ufipc_checker (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // register bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // parity and interrupt
  input wire logic [7:0] tx_data_i,
  input wire ufipc_pkg::ufipc_cfg_s cfg_o,
  input wire logic tx_par_bit_o,
  input wire logic irq_o
);
  import ufipc_pkg::*;
  // one domain, so clock and reset are given once
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // expected parity bits, one cycle ahead of the registered output
  logic exp_force_one;
  logic exp_even_odd;
  assign exp_force_one = (cfg_o.parity == parity_forced_one);
  assign exp_even_odd = ^tx_data_i ^ (cfg_o.parity == parity_odd);
  a_ack_one_cycle: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o) else $error("bad ack");
  a_no_stray_ack: assert property (
    !wb_stb_i |=> !wb_ack_o) else $error("ack without request");
  a_reset_state: assert property (
    $fell(rst_i) |-> !irq_o && !wb_ack_o && cfg_o == '0) else $error("bad reset state");
  a_cfg_by_write: assert property (
    $changed(cfg_o) |-> wb_ack_o && $past(wb_we_i) && $past(wb_adr_i) == OFS_CTRL)
    else $error("config moved without write");
  a_par_forced: assert property (
    cfg_o.parity inside {parity_forced_one, parity_forced_zero}
    |=> tx_par_bit_o == $past(exp_force_one)) else $error("forced parity");
  a_par_even_odd: assert property (
    cfg_o.parity inside {parity_even, parity_odd}
    |=> tx_par_bit_o == $past(exp_even_odd)) else $error("parity");
  a_irq_masked: assert property (
    wb_ack_o && !wb_we_i && wb_adr_i == OFS_MIS |-> $past(irq_o) == |wb_dat_o)
    else $error("irq disagrees with masked status");
  a_zero_data: assert property (
    wb_ack_o && (wb_we_i || wb_adr_i > OFS_IDIS) |-> wb_dat_o == '0) else $error("dat not 0");
  // main scenarios reached
  c_write: cover property (wb_ack_o && wb_we_i);
  c_irq: cover property (irq_o);
  c_forced: cover property (cfg_o.parity == parity_forced_one);
endmodule
bind ufipc_ctrl ufipc_checker chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
  .wb_adr_i, .wb_dat_o, .wb_ack_o, .tx_data_i, .cfg_o, .tx_par_bit_o, .irq_o);
`default_nettype wire

// ===== tb/ufipc_remote.sv
// remote serial device: drives the modem status pins after a line lag
`timescale 1ns/1ns
`default_nettype none
module ufipc_remote #(
  parameter int LAG = 3 // edges between request and pin change
) (
  // clock
  input wire logic clk_i,
  // pins wanted and pins driven
  input wire ufipc_pkg::ufipc_modem_s want_i,
  output ufipc_pkg::ufipc_modem_s modem_o
);
  // a delay line, so pins never move in step with the bench
  ufipc_pkg::ufipc_modem_s pipe_r [LAG];
  always @(posedge clk_i) begin
    pipe_r[0] <= want_i;
    for (int k = 1; k < LAG; k++) begin
      pipe_r[k] <= pipe_r[k-1];
    end
  end
  assign modem_o = pipe_r[LAG-1];
endmodule
`default_nettype wire

// ===== tb/ufipc_ctrl_tb_top.sv
// self-checking bench for the serial port control block
`timescale 1ns/1ns
`default_nettype none
module ufipc_ctrl_tb_top;
  import ufipc_pkg::*;
  // ****************************************************************
  // stimulus signals and scoreboard
  // ****************************************************************
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, rxv = 0, rxp = 0;
  logic [7:0] adr = 0, txd = 0, rxd = 0;
  logic [31:0] wdat = 0, rdat;
  logic [4:0] txl = 0, rxl = 0;
  ufipc_err_s err = '0;
  ufipc_modem_s want = '0, modem;
  ufipc_cfg_s cfg;
  logic ack, txpar, irq;
  logic [31:0] expq[$]; // expected read data, oldest first
  int n_mismatch = 0, checks = 0, cycles = 0, seed = 32'h70431F5F;
  always #4 clk_i = ~clk_i;
  ufipc_remote #(.LAG(3)) remote (.clk_i, .want_i(want), .modem_o(modem));
  ufipc_ctrl #(.DEPTH(16)) dut (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .tx_level_i(txl), .rx_level_i(rxl), .err_evt_i(err),
    .tx_data_i(txd), .rx_valid_i(rxv), .rx_data_i(rxd), .rx_par_i(rxp),
    .modem_i(modem), .cfg_o(cfg), .tx_par_bit_o(txpar), .irq_o(irq));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // one classic cycle; the request stands until ack is seen at an edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
    do @(posedge clk_i); while (ack !== 1'b1);
    {cyc, stb, we} <= 3'h0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    expq.push_back(e);
    bus(0, a, 0);
  endtask
  // random characters for the parity path, read monitor, hang guard
  always @(posedge clk_i) begin
    txd <= 8'($random(seed));
    cycles++;
    if (ack === 1'b1 && !we) check(rdat, expq.pop_front());
    // hang guard last, so nothing runs after the closing report
    if (cycles == 4000) begin
      n_mismatch++;
      wrap_up;
    end
  end
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 0;
    rd(OFS_CTRL, 0);
    rd(OFS_LVL, 32'h12);
    rd(8'h1C, 0);
    // every parity code, then an illegal one that must not stick
    for (int p = 0; p < 6; p++) begin
      bus(1, OFS_CTRL, p << 3 | 7);
      rd(OFS_CTRL, (p > 4 ? 4 : p) << 3 | 7);
      repeat (4) @(posedge clk_i);
    end
    for (int t = 0; t < 5; t++) begin
      bus(1, OFS_LVL, (4 - t) << 3 | t);
      rd(OFS_LVL, (4 - t) << 3 | t);
    end
    // codes above seven eighths are refused, both fields keep their value
    bus(1, OFS_LVL, 32'h3F);
    rd(OFS_LVL, 32'h04);
    // fifo on, even parity; raise all eleven sources while masked
    bus(1, OFS_CTRL, 32'h09);
    {err, rxv, rxd, rxp, txl, rxl, want} <= {4'hF, 1'b1, 8'h01, 1'b0, 5'd15, 5'd2, 4'hF};
    @(posedge clk_i);
    {err, rxv, txl} <= {4'h0, 1'b0, 5'd14};
    repeat (10) @(posedge clk_i);
    check(irq, 0);
    rd(OFS_RIS, 32'h7FF);
    rd(OFS_MIS, 0);
    bus(1, OFS_IEN, 32'h7FF);
    check(irq, 1);
    bus(1, OFS_IDIS, 32'h0FF);
    rd(OFS_IEN, 32'h700);
    rd(OFS_MIS, 32'h700);
    bus(1, OFS_ICLR, 32'h700);
    check(irq, 0);
    rd(OFS_RIS, 32'h0FF);
    bus(1, OFS_IEN, 32'h040);
    bus(1, OFS_ICLR, 32'h0BF);
    rd(OFS_MIS, 32'h040);
    rxl <= 1;
    repeat (2) @(posedge clk_i);
    check(irq, 0);
    rd(OFS_RIS, 0);
    // fifo off: receive threshold drops to one entry, level 1 now reaches it
    bus(1, OFS_CTRL, 32'h08);
    @(posedge clk_i);
    check(irq, 1);
    rd(OFS_RIS, 32'h040);
    wrap_up;
  end
endmodule
`default_nettype wire
